// *** hw/tcrs_ms_timer.sv ***
// Millisecond divider and elapsed-time counter for the boot delay
`timescale 1ns/100ps
`default_nettype none
module tcrs_ms_timer
  import tcrs_pkg::*;
#(
  parameter int MS_CYCLES = TCRS_MS_CYCLES
) (
  input  wire logic     sys_clk,
  input  wire logic     reset,
  tcrs_timer_if.timer   tmr
);

  localparam int CW = $clog2(MS_CYCLES + 1);

  logic [CW-1:0] cyc_reg;
  logic [CW-1:0] cyc_next;
  logic [9:0]    ms_reg;
  logic [9:0]    ms_next;
  wire           tick;

  // ****************************************************************
  // Divider
  // ****************************************************************
  assign tick     = (cyc_reg == CW'(MS_CYCLES - 1));
  assign cyc_next = (tmr.restart || tick) ? '0 : cyc_reg + 1'b1;
  // Saturates so a stalled boot never wraps back under its target
  assign ms_next  = tmr.restart ? 10'h000 :
                    (tick && ms_reg != TCRS_MS_SAT) ? ms_reg + 10'h001 : ms_reg;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cyc_reg <= '0;
      ms_reg  <= 10'h000;
    end else begin
      cyc_reg <= cyc_next;
      ms_reg  <= ms_next;
    end
  end

  assign tmr.ms_tick    = tick;
  assign tmr.elapsed_ms = ms_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  ms_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
    !tmr.restart && !tick |=> $stable(ms_reg))
    else $error("elapsed time moved without a tick");
  ms_clear_a: assert property (@(posedge sys_clk) disable iff (reset)
    tmr.restart |=> ms_reg == 10'h000 && cyc_reg == '0)
    else $error("timer not cleared by restart");

endmodule
`default_nettype wire

// *** hw/tcrs_pkg.sv ***
// Constants and types shared by the touch controller reset and startup sequencer
package tcrs_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int TCRS_CLK_PERIOD_NS = 40;
  localparam int TCRS_NS_PER_MS     = 1000000;
  localparam int TCRS_MS_CYCLES     = TCRS_NS_PER_MS / TCRS_CLK_PERIOD_NS;
  localparam int TCRS_RST_MIN_NS    = 90;
  // Least time: rounded up to whole cycles
  localparam int TCRS_RST_MIN_CYC   =
    (TCRS_RST_MIN_NS + TCRS_CLK_PERIOD_NS - 1) / TCRS_CLK_PERIOD_NS;

  localparam int TCRS_MS_W = 10;
  localparam logic [9:0] TCRS_HW_MIN_MS  = 10'h05C;
  localparam logic [9:0] TCRS_HW_MAX_MS  = 10'h2A3;
  localparam logic [9:0] TCRS_POR_MIN_MS = 10'h05D;
  localparam logic [9:0] TCRS_POR_MAX_MS = 10'h2A3;
  localparam logic [9:0] TCRS_SW_MIN_MS  = 10'h071;
  localparam logic [9:0] TCRS_SW_MAX_MS  = 10'h2B7;
  localparam logic [9:0] TCRS_MS_SAT     = 10'h3FF;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int TCRS_ADDR_W = 5;
  localparam logic [4:0] TCRS_OFS_CTRL   = 5'h00;
  localparam logic [4:0] TCRS_OFS_CFG    = 5'h04;
  localparam logic [4:0] TCRS_OFS_STATUS = 5'h08;
  localparam logic [4:0] TCRS_OFS_CLEAR  = 5'h0C;
  localparam logic [4:0] TCRS_OFS_ENABLE = 5'h10;
  localparam logic [4:0] TCRS_OFS_MSG    = 5'h14;
  localparam logic [4:0] TCRS_OFS_STATE  = 5'h18;

  localparam int TCRS_CTRL_SWRST_BIT = 0;
  localparam int TCRS_ST_W           = 3;
  localparam int TCRS_ST_DONE_BIT    = 0;
  localparam int TCRS_ST_LATE_BIT    = 1;
  localparam int TCRS_ST_BROWN_BIT   = 2;
  localparam int TCRS_MSG_FLAG_BIT   = 0;
  localparam int TCRS_MSG_PEND_BIT   = 1;

  localparam logic [9:0] TCRS_CFG_RST    = 10'h000;
  localparam logic [2:0] TCRS_ENABLE_RST = 3'h0;
  localparam logic [2:0] TCRS_STATUS_RST = 3'h0;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    TCRS_OFF,
    TCRS_HOLD,
    TCRS_BOOT,
    TCRS_READY
  } tcrs_state_t;

  typedef enum logic [1:0] {
    TCRS_KIND_POR,
    TCRS_KIND_HW,
    TCRS_KIND_SW
  } tcrs_kind_t;

endpackage

// *** hw/tcrs_timer_if.sv ***
// Link between the sequencer and its millisecond timer
`timescale 1ns/100ps
`default_nettype none
interface tcrs_timer_if;
  logic       restart;
  logic       ms_tick;
  logic [9:0] elapsed_ms;

  modport ctrl  (output restart, input ms_tick, input elapsed_ms);
  modport timer (input restart, output ms_tick, output elapsed_ms);
endinterface
`default_nettype wire

// *** hw/tcrs_top.sv ***
// Reset and startup sequencer of the touch controller
//
// Overview of operation
// - After pin release, ready in 92 to 675 ms depending on configuration.
// - After power-up, ready in 93 to 675 ms depending on configuration.
// - Software reset command restarts device, ready in 113 to 695 ms.
// - Each completed reset sets the reset flag in the command message.
// - Initialization stalls and no communication while any supply is missing.
// - Attention line is active-low open-drain, flags a pending message.
// - After a reset completes the attention line is asserted.
`timescale 1ns/100ps
`default_nettype none
module tcrs_top
  import tcrs_pkg::*;
#(
  parameter int MS_CYCLES   = TCRS_MS_CYCLES,
  parameter int RST_MIN_CYC = TCRS_RST_MIN_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        rst_pin_n,
  input  wire logic        core_supply_ok,
  input  wire logic        analog_supply_ok,
  input  wire logic        io_supply_ok,
  input  wire logic        drive_supply_ok,
  input  wire logic [4:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             comm_ready,
  input  wire logic        host_attention_line_i,
  output logic             host_attention_line_o,
  output logic             host_attention_line_oe,
  output logic             irq
);

  localparam int LW = $clog2(RST_MIN_CYC + 1);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  tcrs_timer_if tmr ();

  tcrs_state_t     state_reg;
  tcrs_state_t     state_next;
  tcrs_kind_t      kind_reg;
  tcrs_kind_t      kind_next;
  logic [LW-1:0]   low_cnt_reg;
  logic [LW-1:0]   low_cnt_next;
  logic [9:0]      cfg_reg;
  logic [9:0]      cfg_next;
  logic [2:0]      status_reg;
  logic [2:0]      status_next;
  logic [2:0]      enable_reg;
  logic [2:0]      enable_next;
  logic            msg_flag_reg;
  logic            msg_flag_next;
  logic            msg_pend_reg;
  logic            msg_pend_next;
  logic [31:0]     rdata_reg;
  logic [31:0]     rdata_next;

  wire             all_ok;
  wire             pin_reset;
  wire             pin_release;
  wire             running;
  wire             sw_rst;
  wire             sw_go;
  wire [9:0]       target_ms;
  wire             boot_done;
  wire             enter_ready;
  wire             ev_late;
  wire             ev_brown;
  wire [2:0]       ev_vec;
  wire [2:0]       clr_mask;
  wire             msg_rd;
  wire             wr_cfg;
  wire             wr_enable;
  wire [31:0]      rd_mux;
  wire [31:0]      state_view;

  // ****************************************************************
  // Boot delay per reset kind
  // ****************************************************************
  // The configuration part of the delay is clamped so a bad setting can
  // never push readiness past the documented maximum for the kind.
  function automatic logic [9:0] tcrs_boot_target(tcrs_kind_t k, logic [9:0] extra);
    logic [9:0] base;
    logic [9:0] top;
    logic [9:0] span;
    base = TCRS_POR_MIN_MS;
    top  = TCRS_POR_MAX_MS;
    unique case (k)
      TCRS_KIND_POR: begin
        base = TCRS_POR_MIN_MS;
        top  = TCRS_POR_MAX_MS;
      end
      TCRS_KIND_HW: begin
        base = TCRS_HW_MIN_MS;
        top  = TCRS_HW_MAX_MS;
      end
      TCRS_KIND_SW: begin
        base = TCRS_SW_MIN_MS;
        top  = TCRS_SW_MAX_MS;
      end
      default: begin
        base = TCRS_POR_MIN_MS;
        top  = TCRS_POR_MAX_MS;
      end
    endcase
    span = top - base;
    return base + ((extra > span) ? span : extra);
  endfunction

  // ****************************************************************
  // Pin filter and supply monitor
  // ****************************************************************
  assign all_ok = core_supply_ok & analog_supply_ok & io_supply_ok & drive_supply_ok;

  assign low_cnt_next = rst_pin_n ? '0 :
                        (low_cnt_reg == LW'(RST_MIN_CYC)) ? low_cnt_reg :
                        low_cnt_reg + 1'b1;
  // Shorter low pulses are glitches and are ignored
  assign pin_reset   = !rst_pin_n && (low_cnt_reg >= LW'(RST_MIN_CYC - 1));
  assign pin_release = (state_reg == TCRS_HOLD) && rst_pin_n;
  assign running     = (state_reg == TCRS_BOOT) || (state_reg == TCRS_READY);

  // ****************************************************************
  // Register decode
  // ****************************************************************
  assign sw_rst    = reg_wr && reg_addr == TCRS_OFS_CTRL && reg_wdata[TCRS_CTRL_SWRST_BIT];
  assign sw_go     = sw_rst && all_ok && !pin_reset && running;
  assign wr_cfg    = reg_wr && reg_addr == TCRS_OFS_CFG;
  assign wr_enable = reg_wr && reg_addr == TCRS_OFS_ENABLE;
  assign clr_mask  = (reg_wr && reg_addr == TCRS_OFS_CLEAR) ? reg_wdata[2:0] : 3'h0;
  assign msg_rd    = reg_rd && reg_addr == TCRS_OFS_MSG;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  assign target_ms = tcrs_boot_target(kind_reg, cfg_reg);
  assign boot_done = (state_reg == TCRS_BOOT) && (tmr.elapsed_ms >= target_ms);

  always_comb begin
    state_next = state_reg;
    kind_next  = kind_reg;
    if (pin_reset) begin
      state_next = TCRS_HOLD;
      kind_next  = TCRS_KIND_HW;
    end else begin
      unique case (state_reg)
        TCRS_OFF: begin
          if (all_ok) begin
            state_next = TCRS_BOOT;
          end
        end
        TCRS_HOLD: begin
          if (rst_pin_n) begin
            state_next = all_ok ? TCRS_BOOT : TCRS_OFF;
          end
        end
        TCRS_BOOT, TCRS_READY: begin
          if (!all_ok) begin
            state_next = TCRS_OFF;
            kind_next  = TCRS_KIND_POR;
          end else if (sw_go) begin
            state_next = TCRS_BOOT;
            kind_next  = TCRS_KIND_SW;
          end else if (boot_done) begin
            state_next = TCRS_READY;
          end
        end
      endcase
    end
  end

  // Timer restarts on every entry to boot, including a repeated command
  assign tmr.restart = (state_next == TCRS_BOOT) && ((state_reg != TCRS_BOOT) || sw_go);
  assign enter_ready = (state_reg == TCRS_BOOT) && (state_next == TCRS_READY);

  // ****************************************************************
  // Events, message and interrupt
  // ****************************************************************
  assign ev_late  = pin_release && !(analog_supply_ok && drive_supply_ok);
  assign ev_brown = running && (state_next == TCRS_OFF) && !pin_reset;
  assign ev_vec   = {ev_brown, ev_late, enter_ready};

  // Set wins over a clear in the same cycle
  assign status_next   = (status_reg & ~clr_mask) | ev_vec;
  assign msg_flag_next = enter_ready | (msg_flag_reg & !msg_rd);
  assign msg_pend_next = enter_ready | (msg_pend_reg & !msg_rd);
  assign cfg_next      = wr_cfg ? reg_wdata[9:0] : cfg_reg;
  assign enable_next   = wr_enable ? reg_wdata[2:0] : enable_reg;

  // ****************************************************************
  // Read path
  // ****************************************************************
  assign state_view = {22'h000000, comm_ready, host_attention_line_i,
                       drive_supply_ok, io_supply_ok, analog_supply_ok, core_supply_ok,
                       kind_reg, state_reg};
  assign rd_mux = (reg_addr == TCRS_OFS_CFG)    ? {22'h000000, cfg_reg} :
                  (reg_addr == TCRS_OFS_STATUS) ? {29'h00000000, status_reg} :
                  (reg_addr == TCRS_OFS_ENABLE) ? {29'h00000000, enable_reg} :
                  (reg_addr == TCRS_OFS_MSG)    ? {30'h00000000, msg_pend_reg, msg_flag_reg} :
                  (reg_addr == TCRS_OFS_STATE)  ? state_view :
                  32'h00000000;
  assign rdata_next = reg_rd ? rd_mux : 32'h00000000;

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_reg   <= TCRS_OFF;
      kind_reg    <= TCRS_KIND_POR;
      low_cnt_reg <= '0;
    end else begin
      state_reg   <= state_next;
      kind_reg    <= kind_next;
      low_cnt_reg <= low_cnt_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cfg_reg      <= TCRS_CFG_RST;
      status_reg   <= TCRS_STATUS_RST;
      enable_reg   <= TCRS_ENABLE_RST;
      msg_flag_reg <= 1'b0;
      msg_pend_reg <= 1'b0;
      rdata_reg    <= 32'h00000000;
    end else begin
      cfg_reg      <= cfg_next;
      status_reg   <= status_next;
      enable_reg   <= enable_next;
      msg_flag_reg <= msg_flag_next;
      msg_pend_reg <= msg_pend_next;
      rdata_reg    <= rdata_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign reg_rdata  = rdata_reg;
  assign comm_ready = (state_reg == TCRS_READY) && all_ok;
  assign irq        = |(status_reg & enable_reg);
  // Open drain: only ever pulls low, and stays off until boot is over
  assign host_attention_line_o  = 1'b0;
  assign host_attention_line_oe = (state_reg == TCRS_READY) && msg_pend_reg;

  tcrs_ms_timer #(
    .MS_CYCLES (MS_CYCLES)
  ) u_timer (
    .sys_clk (sys_clk),
    .reset   (reset),
    .tmr     (tmr.timer)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence pin_low_seq;
    // First low sample must lie after reset, as the filter counts only then
    !rst_pin_n [*3] ##0 !$past(reset, 2);
  endsequence

  sequence ready_rise_seq;
    $rose(state_reg == TCRS_READY);
  endsequence

  pin_hold_a: assert property (pin_low_seq |=> state_reg == TCRS_HOLD)
    else $error("reset pulse not taken");
  hw_time_a: assert property (ready_rise_seq and kind_reg == TCRS_KIND_HW |->
      $past(tmr.elapsed_ms) >= TCRS_HW_MIN_MS && $past(tmr.elapsed_ms) <= TCRS_HW_MAX_MS)
    else $error("hardware reset ready time out of range");
  por_time_a: assert property (ready_rise_seq and kind_reg == TCRS_KIND_POR |->
      $past(tmr.elapsed_ms) >= TCRS_POR_MIN_MS && $past(tmr.elapsed_ms) <= TCRS_POR_MAX_MS)
    else $error("power-up ready time out of range");
  sw_time_a: assert property (ready_rise_seq and kind_reg == TCRS_KIND_SW |->
      $past(tmr.elapsed_ms) >= TCRS_SW_MIN_MS && $past(tmr.elapsed_ms) <= TCRS_SW_MAX_MS)
    else $error("software reset ready time out of range");
  sw_boot_a: assert property (sw_go |=> state_reg == TCRS_BOOT && tmr.elapsed_ms == 10'h000)
    else $error("software reset did not restart boot");
  reset_flag_a: assert property (ready_rise_seq |-> msg_flag_reg)
    else $error("reset flag missing after reset");
  stall_comm_a: assert property (!all_ok |-> !comm_ready)
    else $error("communication while a supply is missing");
  stall_boot_a: assert property (state_reg == TCRS_OFF && !all_ok && rst_pin_n |=>
      state_reg == TCRS_OFF)
    else $error("initialization left off state without supplies");
  late_flag_a: assert property (pin_release && !analog_supply_ok |=>
      status_reg[TCRS_ST_LATE_BIT])
    else $error("late supply not flagged");
  attn_idle_a: assert property (state_reg != TCRS_READY |-> !host_attention_line_oe)
    else $error("attention driven before ready");
  attn_done_a: assert property (ready_rise_seq |-> host_attention_line_oe)
    else $error("attention not asserted after reset");
  sticky_done_a: assert property (status_reg[TCRS_ST_DONE_BIT] && !clr_mask[TCRS_ST_DONE_BIT]
      |=> status_reg[TCRS_ST_DONE_BIT])
    else $error("status bit lost without clear");

endmodule
`default_nettype wire

// *** verif/tb_touch_ctrl_reset_startup.sv ***
// Self-checking bench for the reset and startup sequencer
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb_touch_ctrl_reset_startup;
  import tcrs_pkg::*;
  localparam int MSC = 4;
  logic        sys_clk;
  logic        reset;
  logic [4:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        comm_ready;
  logic        att_i;
  logic        att_o;
  logic        att_oe;
  logic        irq;
  logic        rst_pin_n;
  logic [3:0]  sup_ok;
  wire         core_ok   = sup_ok[0];
  wire         analog_ok = sup_ok[1];
  wire         io_ok     = sup_ok[2];
  wire         drive_ok  = sup_ok[3];
  logic        rd_seen;
  logic [31:0] exp_q[$];
  string       nm_q[$];
  int          n_mismatch;
  int          total_checks;
  int          cfg;
  logic        ok;

  tcrs_host_model host (.sys_clk(sys_clk), .att_o(att_o), .att_oe(att_oe), .att_i(att_i),
    .rst_pin_n(rst_pin_n), .sup_ok(sup_ok));

  tcrs_top #(.MS_CYCLES(MSC)) uut (.sys_clk(sys_clk), .reset(reset),
    .rst_pin_n(rst_pin_n), .core_supply_ok(core_ok), .analog_supply_ok(analog_ok),
    .io_supply_ok(io_ok), .drive_supply_ok(drive_ok), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .comm_ready(comm_ready), .host_attention_line_i(att_i), .host_attention_line_o(att_o),
    .host_attention_line_oe(att_oe), .irq(irq));

  // ****************************************************************
  // Clock, scoreboard, watchdog
  // ****************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Read data stands only in the cycle after the strobe, so sample exactly there
  always @(posedge sys_clk) begin
    logic [31:0] e;
    string       nm;
    rd_seen <= reg_rd;
    if (rd_seen === 1'b1) begin
      e  = exp_q.pop_front();
      nm = nm_q.pop_front();
      `CHK(nm, e, reg_rdata)
    end
  end

  // Whole run needs about 2400 cycles; five times that means a hang
  initial begin
    repeat (12000) @(posedge sys_clk);
    n_mismatch++;
    tally_and_finish();
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] e, input string nm);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    exp_q.push_back(e);
    nm_q.push_back(nm);
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask

  // Ready must not come early and must come within a small margin
  task automatic wait_ready(input int ms, output logic good);
    int n;
    n = 0;
    // Off the edge, so a state change launched at this edge is settled
    #1;
    while (comm_ready !== 1'b1 && n < ms * MSC + 20) begin
      step(1);
      n++;
    end
    good = (comm_ready === 1'b1) && (n >= ms * MSC - 2);
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    reset = 1'b1;
    reg_addr = 5'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    n_mismatch = 0;
    total_checks = 0;
    void'($urandom(61853));
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    // Reset values, unmapped and write-only places read zero
    step(1);
    `CHK("comm_ready", 1'b0, comm_ready)
    rd(TCRS_OFS_STATUS, 32'h0, "status");
    rd(TCRS_OFS_ENABLE, 32'h0, "enable");
    rd(TCRS_OFS_CFG, 32'h0, "cfg");
    rd(TCRS_OFS_MSG, 32'h0, "msg");
    rd(TCRS_OFS_CTRL, 32'h0, "ctrl");
    rd(5'h1C, 32'h0, "unmapped");
    $display("test reset values done");
    // Drive supply late at pin release: stall, late flag, then boot
    wr(TCRS_OFS_ENABLE, 32'h7);
    host.ramp_held(1'b1);
    step(600);
    `CHK("stall", 1'b0, comm_ready)
    `CHK("irq late", 1'b1, irq)
    rd(TCRS_OFS_STATUS, 32'h2, "late");
    wr(TCRS_OFS_CLEAR, 32'h2);
    step(2);
    `CHK("irq clr", 1'b0, irq)
    host.set_sup(4'hF);
    wait_ready(92, ok);
    `CHK("hw boot", 1'b1, ok)
    `CHK("att oe", 1'b1, att_oe)
    rd(TCRS_OFS_MSG, 32'h3, "msg");
    step(2);
    `CHK("att rel", 1'b0, att_oe)
    $display("test late supply done");
    // Pin reset: short glitch ignored, then three cycles with random config
    cfg = $urandom % 16;
    wr(TCRS_OFS_CFG, {22'($urandom), 10'(cfg)});
    rd(TCRS_OFS_CFG, 32'(cfg), "cfg");
    host.pin_pulse(2);
    step(8);
    `CHK("glitch", 1'b1, comm_ready)
    host.pin_pulse(3);
    step(2);
    `CHK("in reset", 1'b0, comm_ready)
    wait_ready(92 + cfg, ok);
    `CHK("hw cfg", 1'b1, ok)
    rd(TCRS_OFS_STATE, 32'h2F7, "state hw");
    rd(TCRS_OFS_MSG, 32'h3, "msg");
    $display("test pin reset done");
    // Software reset as host recovery, then mask and clear
    wr(TCRS_OFS_CTRL, 32'h1);
    wait_ready(113 + cfg, ok);
    `CHK("sw boot", 1'b1, ok)
    rd(TCRS_OFS_STATE, 32'h2FB, "state sw");
    rd(TCRS_OFS_MSG, 32'h3, "msg");
    wr(TCRS_OFS_ENABLE, 32'h0);
    step(2);
    `CHK("irq mask", 1'b0, irq)
    wr(TCRS_OFS_ENABLE, 32'h1);
    step(2);
    `CHK("irq done", 1'b1, irq)
    wr(TCRS_OFS_CLEAR, 32'h7);
    step(2);
    `CHK("irq none", 1'b0, irq)
    $display("test software reset done");
    // Brownout: analog lost while running, host reconfigures, power-up boot
    host.set_sup(4'hD);
    step(2);
    `CHK("brown", 1'b0, comm_ready)
    wr(TCRS_OFS_STATUS, 32'h7);
    rd(TCRS_OFS_STATUS, 32'h4, "brownout");
    wr(TCRS_OFS_CFG, 32'h0);
    host.set_sup(4'hF);
    wait_ready(93, ok);
    `CHK("por boot", 1'b1, ok)
    rd(TCRS_OFS_STATE, 32'h2F3, "state por");
    rd(TCRS_OFS_MSG, 32'h3, "msg");
    rd(TCRS_OFS_MSG, 32'h0, "msg clr");
    $display("test brownout done");
    step(3);
    tally_and_finish();
  end
endmodule
`default_nettype wire

// *** verif/tcrs_host_model.sv ***
// Host side model: supplies, reset pin and attention pull-up
`timescale 1ns/100ps
`default_nettype none
module tcrs_host_model (
  input  wire logic       sys_clk,
  input  wire logic       att_o,
  input  wire logic       att_oe,
  output logic            att_i,
  output logic            rst_pin_n,
  output logic      [3:0] sup_ok
);
  // ****************************************************************
  // Attention wire
  // ****************************************************************
  // Pull-up wins when released; host never drives the line
  assign att_i = att_oe ? att_o : 1'b1;

  // ****************************************************************
  // Supplies and reset pin
  // ****************************************************************
  // Core off at start, so pin starts low to avoid back-powering
  initial begin
    rst_pin_n = 1'b0;
    sup_ok    = 4'h0;
  end

  // Bits {drive,io,analog,core}; pin forced low whenever core drops
  task automatic set_sup(input logic [3:0] v);
    @(posedge sys_clk);
    sup_ok <= v;
    if (!v[0]) rst_pin_n <= 1'b0;
  endtask

  // Pin low through the ramp; io with core, drive after core
  task automatic ramp_held(input logic drive_late);
    @(posedge sys_clk);
    rst_pin_n <= 1'b0;
    set_sup(4'h5);
    set_sup(4'h7);
    if (!drive_late) set_sup(4'hF);
    repeat (2) @(posedge sys_clk);
    rst_pin_n <= 1'b1;
  endtask

  // Low for n cycles; n below three is a deliberately short glitch
  task automatic pin_pulse(input int n);
    @(posedge sys_clk);
    rst_pin_n <= 1'b0;
    repeat (n) @(posedge sys_clk);
    rst_pin_n <= 1'b1;
  endtask
endmodule
`default_nettype wire
